/* File: pmsc_consts.vh */
// constants for the pluggable module sideband control block
`ifndef PMSC_CONSTS_VH
`define PMSC_CONSTS_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define PMSC_CLK_MHZ        50
`define PMSC_RESET_MIN_NS   2000
`define PMSC_RESET_MIN_CYC  ((`PMSC_RESET_MIN_NS * `PMSC_CLK_MHZ + 999) / 1000)
`define PMSC_INIT_NS        1000000
`define PMSC_INIT_CYC       ((`PMSC_INIT_NS * `PMSC_CLK_MHZ) / 1000)

// ----------------------------------------
// two-wire slave
// ----------------------------------------
`define PMSC_DEV_ADDR       7'h50

// ----------------------------------------
// memory map offsets
// ----------------------------------------
`define PMSC_REG_STATUS     8'h00
`define PMSC_REG_FLAGS      8'h01
`define PMSC_REG_LANE_DIS   8'h02
`define PMSC_REG_MASK       8'h03
`define PMSC_REG_CTRL       8'h04

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define PMSC_ST_NOT_READY   0
`define PMSC_ST_INT_PEND    1
`define PMSC_ST_LP_PIN      2
`define PMSC_ST_PWR_HIGH    3
`define PMSC_FL_RESET_DONE  0
`define PMSC_FL_FAULT_LSB   4
`define PMSC_CTRL_FORCE_LP  0
`define PMSC_LANE_DIS_RST   4'h0
`define PMSC_MASK_RST       8'h00
`define PMSC_CTRL_RST       8'h00

`endif

/* File: pmsc_twi.v */
// two-wire serial slave with select gating and auto-incrementing pointer
`default_nettype none
`include "pmsc_consts.vh"

module pmsc_twi #(
  parameter [6:0] DEV_ADDR = `PMSC_DEV_ADDR
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       sel,
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output reg        sda_oe,
  output reg  [7:0] reg_addr,
  output reg        wr_stb,
  output reg  [7:0] wr_data,
  output reg        rd_stb,
  input  wire [7:0] rd_data
);
  localparam [2:0] S_IDLE = 3'd0, S_ADDR = 3'd1, S_ACKA = 3'd2, S_WDAT = 3'd3,
                   S_ACKW = 3'd4, S_RDAT = 3'd5, S_ACKR = 3'd6;

  reg [1:0] scl_m_r, sda_m_r;
  reg       scl_d_r, sda_d_r;
  reg [2:0] st_r;
  reg [3:0] cnt_r;
  reg [7:0] sh_r;
  reg       rw_r, first_r;
  wire scl_s = scl_m_r[1];
  wire sda_s = sda_m_r[1];
  wire start = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire rise  = scl_s & ~scl_d_r;
  wire fall  = ~scl_s & scl_d_r;

  assign sda_out = 1'b0; // open drain: only ever pulls low

  // pin synchronisers, second stage feeds all logic
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_m_r <= 2'b11;
      sda_m_r <= 2'b11;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_m_r <= {scl_m_r[0], scl_in};
      sda_m_r <= {sda_m_r[0], sda_in};
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // protocol engine
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= S_IDLE; cnt_r <= 4'h0; sh_r <= 8'h00; rw_r <= 1'b0;
      first_r <= 1'b0; sda_oe <= 1'b0; reg_addr <= 8'h00;
      wr_stb <= 1'b0; wr_data <= 8'h00; rd_stb <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      if (rd_stb || wr_stb) reg_addr <= reg_addr + 8'h01; // R12 pointer steps after the strobe
      if (start) begin
        st_r   <= sel ? S_ADDR : S_IDLE; // R1
        cnt_r  <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop || !sel) begin
        st_r   <= S_IDLE; // R1
        sda_oe <= 1'b0;
      end else if (rise) begin
        case (st_r)
          S_ADDR, S_WDAT: begin
            sh_r  <= {sh_r[6:0], sda_s};
            cnt_r <= cnt_r + 4'h1;
          end
          S_RDAT: begin
            sh_r  <= {sh_r[6:0], 1'b0};
            cnt_r <= cnt_r + 4'h1;
          end
          S_ACKR: if (sda_s) st_r <= S_IDLE; // master nack ends read
          default: ;
        endcase
      end else if (fall) begin
        case (st_r)
          S_ADDR: if (cnt_r == 4'h8) begin
            if (sh_r[7:1] == DEV_ADDR) begin
              st_r <= S_ACKA; sda_oe <= 1'b1; rw_r <= sh_r[0];
            end else begin
              st_r <= S_IDLE;
            end
          end
          S_ACKA, S_ACKR: begin
            cnt_r <= 4'h0;
            if (rw_r) begin
              st_r     <= S_RDAT; // R12
              sh_r     <= rd_data;
              sda_oe   <= ~rd_data[7];
              rd_stb   <= 1'b1;
            end else begin
              st_r <= S_WDAT; sda_oe <= 1'b0; first_r <= 1'b1;
            end
          end
          S_WDAT: if (cnt_r == 4'h8) begin
            st_r <= S_ACKW; sda_oe <= 1'b1;
            if (first_r) begin
              reg_addr <= sh_r; first_r <= 1'b0;
            end else begin
              wr_stb <= 1'b1; wr_data <= sh_r; // R12
            end
          end
          S_ACKW: begin
            st_r <= S_WDAT; sda_oe <= 1'b0; cnt_r <= 4'h0;
          end
          S_RDAT: begin
            if (cnt_r == 4'h8) begin
              st_r <= S_ACKR; sda_oe <= 1'b0;
            end else begin
              sda_oe <= ~sh_r[7];
            end
          end
          default: ;
        endcase
      end
    end
  end
endmodule // pmsc_twi
`default_nettype wire

/* File: pmsc_sideband.v */
// top of the pluggable module sideband control: pins, reset sequence, memory map
// How it works
// R1: two-wire transactions answered only while module select is held low
// R2: host drives one select line per module on a shared bus
// R3: module reset held low past minimum pulse restores all defaults
// R4: host ignores status bits until reset completion is signalled
// R5: completion shown by interrupt low with not-ready flag cleared
// R6: power-up runs the same completion sequence with no host reset
// R7: low-power select level picks the maximum allowed power class
// R8: presence line pulled to ground whenever the module is inserted
// R9: interrupt pin pulled low on fault or critical status
// R10: host reads status over two-wire bus to find interrupt source
// R11: interrupt output is open drain, only pulling low or releasing
// R12: memory map readable and writable over the two-wire lines
// R13: each of four lanes addressable and individually shut down
// R14: select, reset and low-power inputs pass two flip-flops first
`default_nettype none
`include "pmsc_consts.vh"

module pmsc_sideband #(
  parameter        LANES    = 4,
  parameter [31:0] INIT_CYC = `PMSC_INIT_CYC,
  parameter [6:0]  DEV_ADDR = `PMSC_DEV_ADDR
) (
  input  wire             clk,
  input  wire             nrst,
  input  wire             module_select_n,
  input  wire             module_reset_n,
  input  wire             low_power_select,
  input  wire             scl_in,
  input  wire             sda_in,
  output wire             sda_out,
  output wire             sda_oe,
  output wire             interrupt_out_n_out,
  output wire             interrupt_out_n_oe,
  output wire             module_present_n_out,
  output wire             module_present_n_oe,
  input  wire [LANES-1:0] lane_fault,
  output reg  [LANES-1:0] lane_shutdown,
  output reg              power_high_allowed,
  output reg              not_ready
);
  localparam [1:0] P_HELD = 2'd0, P_INIT = 2'd1, P_RUN = 2'd2;
  localparam [15:0] RST_MIN = `PMSC_RESET_MIN_CYC;

  // ----------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------
  reg  [1:0] rst_sync_r;
  reg  [2:0] pin_m_r, pin_s_r;
  wire       rst_n = rst_sync_r[1];
  wire       sel_s = ~pin_s_r[0];
  wire       mrst_low = ~pin_s_r[1];
  wire       lp_s  = pin_s_r[2];

  // reset released through two flops
  always @(posedge clk or negedge nrst) begin
    if (!nrst) rst_sync_r <= 2'b00;
    else       rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  // select, module reset and low power through two flops
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_m_r <= 3'b011;
      pin_s_r <= 3'b011;
    end else begin
      pin_m_r <= {low_power_select, module_reset_n, module_select_n}; // R14
      pin_s_r <= pin_m_r; // R14
    end
  end

  // ----------------------------------------
  // module reset pulse filter and start-up sequence
  // ----------------------------------------
  reg  [15:0] rlow_cnt_r;
  reg  [31:0] init_cnt_r;
  reg  [1:0]  ph_r;
  wire        soft_rst = mrst_low && (rlow_cnt_r >= RST_MIN);
  wire        init_done = (ph_r == P_INIT) && (init_cnt_r == INIT_CYC - 32'd1);

  // count how long module reset has stayed low
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)          rlow_cnt_r <= 16'h0000;
    else if (!mrst_low)  rlow_cnt_r <= 16'h0000;
    else if (!soft_rst)  rlow_cnt_r <= rlow_cnt_r + 16'h0001;
  end

  // phase: held in reset, initialising, running
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_r       <= P_INIT; // R6
      init_cnt_r <= 32'h0000_0000;
    end else begin
      case (ph_r)
        P_HELD: if (!mrst_low) begin
          ph_r <= P_INIT;
          init_cnt_r <= 32'h0000_0000;
        end
        P_INIT: begin
          if (soft_rst) ph_r <= P_HELD; // R3
          else if (init_done) ph_r <= P_RUN;
          init_cnt_r <= init_cnt_r + 32'h0000_0001;
        end
        P_RUN: if (soft_rst) ph_r <= P_HELD; // R3
        default: ph_r <= P_HELD;
      endcase
    end
  end

  // ----------------------------------------
  // two-wire slave
  // ----------------------------------------
  wire [7:0] reg_addr, wr_data;
  wire       wr_stb, rd_stb;
  reg  [7:0] rd_data;

  pmsc_twi #(.DEV_ADDR(DEV_ADDR)) u_twi (
    .clk      (clk),
    .rst_n    (rst_n),
    .sel      (sel_s),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_out  (sda_out),
    .sda_oe   (sda_oe),
    .reg_addr (reg_addr),
    .wr_stb   (wr_stb),
    .wr_data  (wr_data),
    .rd_stb   (rd_stb),
    .rd_data  (rd_data)
  );

  // ----------------------------------------
  // memory map
  // ----------------------------------------
  reg  [7:0]       mask_r, ctrl_r;
  reg              rdone_r;
  reg  [LANES-1:0] fault_r;
  reg  [7:0]       rd_seen_r;
  wire [7:0]       flags = {fault_r, 3'b000, rdone_r};
  wire             int_pend = |(flags & ~mask_r);
  wire             flags_rd = rd_stb && (reg_addr == `PMSC_REG_FLAGS);
  wire             held = (ph_r == P_HELD);
  wire [7:0]       status = {4'h0, power_high_allowed, lp_s, int_pend, not_ready};

  // writable registers, all back to defaults on module reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lane_shutdown <= `PMSC_LANE_DIS_RST;
      mask_r        <= `PMSC_MASK_RST;
      ctrl_r        <= `PMSC_CTRL_RST;
    end else if (held) begin
      lane_shutdown <= `PMSC_LANE_DIS_RST; // R3
      mask_r        <= `PMSC_MASK_RST; // R3
      ctrl_r        <= `PMSC_CTRL_RST; // R3
    end else if (wr_stb) begin
      case (reg_addr)
        `PMSC_REG_LANE_DIS: lane_shutdown <= wr_data[LANES-1:0]; // R13
        `PMSC_REG_MASK:     mask_r <= wr_data;
        `PMSC_REG_CTRL:     ctrl_r <= wr_data;
        default: ;
      endcase
    end
  end

  // byte handed to the shifter, so clear-on-read drops only bits the host saw
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) rd_seen_r <= 8'h00;
    else        rd_seen_r <= rd_data;
  end

  // reset-done flag: set wins over clear-on-read
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)         rdone_r <= 1'b0;
    else if (held)      rdone_r <= 1'b0; // R3
    else if (init_done) rdone_r <= 1'b1; // R5
    else if (flags_rd && rd_seen_r[`PMSC_FL_RESET_DONE]) rdone_r <= 1'b0;
  end

  // per-lane sticky fault flags
  genvar i;
  generate
    for (i = 0; i < LANES; i = i + 1) begin : g_lane
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n)             fault_r[i] <= 1'b0;
        else if (held)          fault_r[i] <= 1'b0;
        else if (lane_fault[i]) fault_r[i] <= 1'b1; // R9
        else if (flags_rd && rd_seen_r[`PMSC_FL_FAULT_LSB + i]) fault_r[i] <= 1'b0;
      end
    end
  endgenerate

  // read mux, unmapped offsets read zero
  always @* begin
    case (reg_addr)
      `PMSC_REG_STATUS:   rd_data = status; // R10
      `PMSC_REG_FLAGS:    rd_data = flags; // R10
      `PMSC_REG_LANE_DIS: rd_data = {{(8-LANES){1'b0}}, lane_shutdown};
      `PMSC_REG_MASK:     rd_data = mask_r;
      `PMSC_REG_CTRL:     rd_data = ctrl_r;
      default:            rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------
  // status outputs and pins
  // ----------------------------------------
  reg int_drive_r;

  // not-ready flag and power class
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      not_ready          <= 1'b1;
      power_high_allowed <= 1'b0;
      int_drive_r        <= 1'b0;
    end else begin
      not_ready          <= (ph_r != P_RUN) && !init_done; // R5
      power_high_allowed <= !lp_s && !ctrl_r[`PMSC_CTRL_FORCE_LP] && (ph_r == P_RUN); // R7
      int_drive_r        <= int_pend && !held; // R9
    end
  end

  // open-drain interrupt: pulls low or releases
  assign interrupt_out_n_out = 1'b0; // R11
  assign interrupt_out_n_oe  = int_drive_r; // R11

  // presence pin tied to ground inside the module
  assign module_present_n_out = 1'b0; // R8
  assign module_present_n_oe  = 1'b1; // R8
endmodule // pmsc_sideband
`default_nettype wire

/* File: pmsc_dummy_unused.v */
// spare design file, holds no logic
`default_nettype none
`default_nettype wire

/* File: pmsc_sideband_checker.sv */
// assertions and covers on the sideband control pins
`default_nettype none
module pmsc_sideband_checker #(
  parameter        LANES    = 4,
  parameter [31:0] INIT_CYC = 20
) (
  input wire logic             clk,
  input wire logic             nrst,
  input wire logic             module_select_n,
  input wire logic             module_reset_n,
  input wire logic             low_power_select,
  input wire logic             sda_oe,
  input wire logic             interrupt_out_n_out,
  input wire logic             interrupt_out_n_oe,
  input wire logic             module_present_n_oe,
  input wire logic [LANES-1:0] lane_shutdown,
  input wire logic             power_high_allowed,
  input wire logic             not_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  low_r;
  logic [31:0] since_r;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // reset pin low time, and cycles since the last start-up began
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_r   <= 8'h00;
      since_r <= 32'h0000_0000;
    end else begin
      low_r   <= module_reset_n ? 8'h00 : ((low_r == 8'hFF) ? low_r : low_r + 8'h01);
      since_r <= (low_r >= 8'h69) ? 32'h0000_0000 : since_r + 32'h0000_0001;
    end
  end
  a_present_ground: assert property (module_present_n_oe)
    else $error("presence line released");
  a_int_open_drain: assert property (!interrupt_out_n_out)
    else $error("interrupt pin driven high");
  a_done_int: assert property ($fell(not_ready) |-> ##[0:2] interrupt_out_n_oe)
    else $error("no interrupt at end of start-up");
  a_reset_defaults: assert property (low_r >= 8'h6E |->
    not_ready && !interrupt_out_n_oe && lane_shutdown == '0 && !power_high_allowed)
    else $error("long module reset left state");
  a_low_power: assert property (low_power_select [*6] |-> !power_high_allowed)
    else $error("high power allowed in low power");
  a_select_gate: assert property (module_select_n [*8] |-> !sda_oe)
    else $error("data line pulled while unselected");
  a_lane_by_bus: assert property (!$stable(lane_shutdown) && lane_shutdown != '0 |->
    !$past(module_select_n, 3))
    else $error("lane shutdown changed without access");
  a_init_holds: assert property (since_r < INIT_CYC |-> not_ready)
    else $error("ready before start-up ran");
  a_init_ends: assert property (since_r == INIT_CYC + 32'h0000_0014 |-> !not_ready)
    else $error("start-up never completed");
  c_done: cover property ($fell(not_ready));
  c_ack: cover property ($rose(sda_oe));
  c_long_reset: cover property (low_r == 8'h6E);
endmodule // pmsc_sideband_checker
`default_nettype wire

/* File: pmsc_host_model.sv */
// host board controller model: two-wire master, select line and pull-up
`default_nettype none
`include "pmsc_consts.vh"
module pmsc_host_model (
  input  wire logic clk,
  input  wire logic dev_sda_oe,
  output var  logic scl,
  output wire logic sda,
  output var  logic sel_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv_low = 1'h0;
  int   hp      = 8;
  // shared data wire: either side pulls low, the pull-up wins otherwise
  assign sda = !(drv_low || dev_sda_oe);
  initial begin
    scl   = 1'h1;
    sel_n = 1'h1;
  end
  task automatic half();
    repeat (hp) @(negedge clk);
  endtask
  // start (st=1) or stop (st=0) condition
  task automatic cond(input logic st);
    half();
    drv_low = !st;
    half();
    scl = 1'h1;
    half();
    drv_low = st;
    half();
    scl = !st;
  endtask
  task automatic bitx(input logic b, output logic r);
    half();
    drv_low = !b;
    half();
    scl = 1'h1;
    half();
    half();
    r = sda;
    scl = 1'h0;
  endtask
  task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] q,
                       output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(last, r);
    ack = !r;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic en,
                    output logic ok);
    logic [7:0] q;
    logic       k0, k1, k2;
    sel_n = !en;
    cond(1'h1);
    xbyte({`PMSC_DEV_ADDR, 1'h0}, 1'h1, q, k0);
    xbyte(a, 1'h1, q, k1);
    xbyte(v, 1'h1, q, k2);
    cond(1'h0);
    sel_n = 1'h1;
    ok = k0 & k1 & k2;
    half();  // select stays high between transfers
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    logic k;
    sel_n = 1'h0;
    cond(1'h1);
    xbyte({`PMSC_DEV_ADDR, 1'h0}, 1'h1, q, k);
    xbyte(a, 1'h1, q, k);
    cond(1'h1);
    xbyte({`PMSC_DEV_ADDR, 1'h1}, 1'h1, q, k);
    xbyte(8'hFF, 1'h1, q, k);
    cond(1'h0);
    sel_n = 1'h1;
    half();  // select stays high between transfers
  endtask
endmodule // pmsc_host_model
`default_nettype wire

/* File: test_pmsc_sideband.sv */
// testbench for the pluggable module sideband control block
`default_nettype none
module test_pmsc_sideband;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [31:0] INIT = 20;
  logic clk = 1'h0, nrst = 1'h0, module_reset_n = 1'h1, low_power_select = 1'h0, ok;
  logic [3:0] lane_fault = 4'h0;
  logic [7:0] q, d, f;
  wire logic [3:0] lane_shutdown;
  wire logic module_select_n, scl_in, sda_in, sda_out, sda_oe, interrupt_out_n_out,
    interrupt_out_n_oe, module_present_n_out, module_present_n_oe, power_high_allowed, not_ready;
  int errors = 0, checks_done = 0, cyc = 0, seed = 32'h0000_1511;
  always #10 clk = ~clk;
  pmsc_sideband #(.INIT_CYC(INIT)) pmsc_sideband_inst (.clk, .nrst, .module_select_n,
    .module_reset_n, .low_power_select, .scl_in, .sda_in, .sda_out, .sda_oe,
    .interrupt_out_n_out, .interrupt_out_n_oe, .module_present_n_out, .module_present_n_oe,
    .lane_fault, .lane_shutdown, .power_high_allowed, .not_ready);
  pmsc_host_model pmsc_host_model_inst (.clk, .dev_sda_oe(sda_oe), .scl(scl_in),
    .sda(sda_in), .sel_n(module_select_n));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h got %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [7:0] status(input logic lpin, ph, ip, nr);
    return {4'h0, ph, lpin, ip, nr};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    pmsc_host_model_inst.wr(a, v, 1'h1, ok);
    chk("ack", 8'h01, {7'h0, ok});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    pmsc_host_model_inst.rd(a, q);
    chk(nm, e, q);
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 400 && not_ready !== 1'h0; i++) @(negedge clk);
    repeat (3) @(negedge clk);
  endtask
  task automatic pulse(input logic rl, input int n, input logic [3:0] fl);
    module_reset_n = !rl;
    lane_fault = fl;
    repeat (n) @(negedge clk);
    module_reset_n = 1'h1;
    lane_fault = 4'h0;
    repeat (4) @(negedge clk);
  endtask
  // cycle ceiling against a hung transfer
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      errors++;
      final_report();
    end
  end
  // main sequence
  initial begin
    repeat (16) @(negedge clk);
    nrst = 1'h1;
    chk("not_ready", 8'h01, {7'h0, not_ready});
    chk("present", 8'h01, {7'h0, module_present_n_oe});
    chk("pins_out", 8'h00, {6'h0, sda_out, module_present_n_out});
    wait_ready();
    chk("int_oe", 8'h01, {7'h0, interrupt_out_n_oe});
    rd(8'h00, status(1'h0, 1'h1, 1'h1, 1'h0), "status");
    rd(8'h01, 8'h01, "flags");
    rd(8'h01, 8'h00, "flags_clr");
    chk("int_oe", 8'h00, {7'h0, interrupt_out_n_oe});
    $display("test power-up done");
    for (int i = 0; i < 6; i++) begin
      pmsc_host_model_inst.hp = (i % 2) ? 3 : 8;
      d = 8'($random(seed));
      wr(8'h02, d);
      chk("lanes", {4'h0, d[3:0]}, {4'h0, lane_shutdown});
      rd(8'h02, {4'h0, d[3:0]}, "lanes_rd");
    end
    pmsc_host_model_inst.wr(8'h02, ~d, 1'h0, ok);
    chk("ack_unsel", 8'h00, {7'h0, ok});
    chk("lanes_unsel", {4'h0, d[3:0]}, {4'h0, lane_shutdown});
    $display("test lanes done");
    low_power_select = 1'h1;
    repeat (8) @(negedge clk);
    chk("power", 8'h00, {7'h0, power_high_allowed});
    rd(8'h00, status(1'h1, 1'h0, 1'h0, 1'h0), "status_lp");
    rd(8'h07, 8'h00, "unmapped");
    low_power_select = 1'h0;
    wr(8'h04, 8'h01);
    chk("power_forced", 8'h00, {7'h0, power_high_allowed});
    wr(8'h04, 8'h00);
    chk("power", 8'h01, {7'h0, power_high_allowed});
    $display("test power done");
    f = 8'h10 << ($random(seed) & 3);
    pulse(1'h0, 2, f[7:4]);
    chk("int_fault", 8'h01, {7'h0, interrupt_out_n_oe});
    rd(8'h01, f, "flags_fault");
    chk("int_clr", 8'h00, {7'h0, interrupt_out_n_oe});
    wr(8'h03, 8'hF0);
    pulse(1'h0, 2, f[7:4]);
    chk("int_masked", 8'h00, {7'h0, interrupt_out_n_oe});
    wr(8'h03, 8'h00);
    chk("int_unmask", 8'h01, {7'h0, interrupt_out_n_oe});
    rd(8'h01, f, "flags_masked");
    $display("test fault done");
    wr(8'h02, 8'h0F);
    wr(8'h03, 8'h0F);
    pulse(1'h1, 50, 4'h0);
    chk("lanes_short", 8'h0F, {4'h0, lane_shutdown});
    pulse(1'h1, 150, 4'h0);
    chk("lanes_rst", 8'h00, {4'h0, lane_shutdown});
    chk("not_ready_rst", 8'h01, {7'h0, not_ready});
    wait_ready();
    chk("int_done", 8'h01, {7'h0, interrupt_out_n_oe});
    rd(8'h03, 8'h00, "mask_rst");
    rd(8'h01, 8'h01, "flags_done");
    $display("test module reset done");
    final_report();
  end
endmodule // test_pmsc_sideband
bind pmsc_sideband pmsc_sideband_checker #(.LANES(LANES), .INIT_CYC(INIT_CYC))
  pmsc_sideband_checker_inst (.clk, .nrst, .module_select_n, .module_reset_n,
  .low_power_select, .sda_oe, .interrupt_out_n_out, .interrupt_out_n_oe,
  .module_present_n_oe, .lane_shutdown, .power_high_allowed, .not_ready);
`default_nettype wire
